// >>> logic/fcus_cfg.svh
// Constants of the flash command unlock sequencer: offsets, codes, reset values.
// Assumes a 16-bit register address space and 8-bit register data.
`ifndef FCUS_CFG_SVH
`define FCUS_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FCUS_ADDR_CMD 16'h0FF8
`define FCUS_ADDR_SPROT 16'h0FF9
`define FCUS_ADDR_STATUS 16'h0FFA
`define FCUS_ADDR_LOT_LO 16'hFE3C
`define FCUS_ADDR_LOT_HI 16'hFE7D

// ------------------------------------------------------------
// Command codes and reset values
// ------------------------------------------------------------
`define FCUS_CODE_UNLOCK1 8'h73
`define FCUS_CODE_UNLOCK2 8'h8C
`define FCUS_CODE_PAGE_ERASE 8'h95
`define FCUS_CODE_MASS_ERASE 8'h63
`define FCUS_CODE_SPROT 8'h5E
`define FCUS_CMD_RESET 8'h00
`define FCUS_SPROT_RESET 8'h00

// ------------------------------------------------------------
// Status register field positions
// ------------------------------------------------------------
`define FCUS_ST_UNLOCKED 0
`define FCUS_ST_FIRST 1
`define FCUS_ST_SPROT_OPEN 2

`endif

// >>> logic/fcus_pkg.sv
// Types shared by the flash command unlock sequencer.
// Assumes fcus_cfg.svh is compiled alongside for the numeric constants.
package fcus_pkg;

    // ------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fcus_bus_t;

    // ------------------------------------------------------------
    // Decoded command and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FCUS_CMD_UNLOCK1,
        FCUS_CMD_UNLOCK2,
        FCUS_CMD_PAGE_ERASE,
        FCUS_CMD_MASS_ERASE,
        FCUS_CMD_SPROT,
        FCUS_CMD_OTHER
    } fcus_cmd_t;

    typedef enum logic [1:0] {
        FCUS_LOCKED,
        FCUS_FIRST_SEEN,
        FCUS_UNLOCKED
    } fcus_state_t;

endpackage

// >>> logic/fcus_cmd_dec.sv
// Command byte decoder for the flash command unlock sequencer.
// Assumes the byte is only meaningful while a command register write is present.
`timescale 1ns/1ps
`include "fcus_cfg.svh"

module fcus_cmd_dec
    import fcus_pkg::*;
(
    input wire logic [7:0] code,
    output fcus_cmd_t cmd
);
    always_comb begin
        case (code)
            `FCUS_CODE_UNLOCK1: cmd = FCUS_CMD_UNLOCK1;
            `FCUS_CODE_UNLOCK2: cmd = FCUS_CMD_UNLOCK2;
            `FCUS_CODE_PAGE_ERASE: cmd = FCUS_CMD_PAGE_ERASE;
            `FCUS_CODE_MASS_ERASE: cmd = FCUS_CMD_MASS_ERASE;
            `FCUS_CODE_SPROT: cmd = FCUS_CMD_SPROT;
            default: cmd = FCUS_CMD_OTHER;
        endcase
    end
endmodule // fcus_cmd_dec

// >>> logic/fcus_lot_rom.sv
// Randomized lot identifier lookup in the information page.
// Assumes the 32 identifier bytes arrive as one 256-bit word, byte 0 in the low bits.
`timescale 1ns/1ps

module fcus_lot_rom (
    input wire logic [255:0] lot_id,
    input wire logic [15:0] addr,
    output logic hit,
    output logic [7:0] data
);
    // Byte 31 at the first entry down to byte 0 at the last; the map has gaps.
    localparam logic [7:0] LOT_MAP [32] = '{
        8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h58, 8'h59, 8'h5A, 8'h5B,
        8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h61, 8'h62, 8'h64, 8'h65,
        8'h67, 8'h68, 8'h6A, 8'h6B, 8'h6D, 8'h6E, 8'h70, 8'h71,
        8'h73, 8'h74, 8'h76, 8'h77, 8'h79, 8'h7A, 8'h7C, 8'h7D
    };

    always_comb begin
        hit = 1'b0;
        data = 8'h00;
        for (int i = 0; i < 32; i++) begin
            if (addr == {8'hFE, LOT_MAP[i]}) begin
                hit = 1'b1;
                data = lot_id[8*(31-i) +: 8];
            end
        end
    end
endmodule // fcus_lot_rom

// >>> logic/fcus_top.sv
// Flash command unlock sequencer: command register, unlock state machine,
// erase start pulses, sector protect register and lot identifier reads.
// Assumes a register master that drives one-cycle strobes synchronous to clock
// and a flash array that latches the erase pulses and the page number itself.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "fcus_cfg.svh"

module fcus_top
    import fcus_pkg::*;
#(
    // Arbitrary lot identifier value; a real part fuses its own.
    parameter logic [255:0] LOT_ID = {8{32'h5A5A_C3C3}}
) (
    input wire logic clock,
    input wire logic rst_b,
    input fcus_bus_t bus_req,
    input wire logic [6:0] page_select,
    output logic [7:0] rd_data_r,
    output logic page_erase_go_r,
    output logic mass_erase_go_r,
    output logic [6:0] erase_page_r,
    output logic [7:0] sector_protect_r,
    output logic unlocked_r
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    fcus_cmd_t cmd;
    logic lot_hit;
    logic [7:0] lot_data;
    logic cmd_wr;
    logic sprot_wr;

    fcus_cmd_dec u_dec (
        .code(bus_req.wdata),
        .cmd(cmd)
    );

    fcus_lot_rom u_lot (
        .lot_id(LOT_ID),
        .addr(bus_req.addr),
        .hit(lot_hit),
        .data(lot_data)
    );

    assign cmd_wr = bus_req.wr && (bus_req.addr == `FCUS_ADDR_CMD);
    assign sprot_wr = bus_req.wr && (bus_req.addr == `FCUS_ADDR_SPROT);

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    fcus_state_t state_r;
    fcus_state_t state_nxt;
    logic [7:0] cmd_code_r;
    logic [7:0] cmd_code_nxt;
    logic page_erase_go_nxt;
    logic mass_erase_go_nxt;
    logic [6:0] erase_page_nxt;
    logic unlocked_nxt;
    logic sprot_open_r;
    logic sprot_open_nxt;

    // The command register is write-only; the last code is kept only
    // so that the decode is visible on a waveform, never read back.
    always_comb begin
        state_nxt = state_r;
        cmd_code_nxt = cmd_code_r;
        page_erase_go_nxt = 1'b0;
        mass_erase_go_nxt = 1'b0;
        erase_page_nxt = erase_page_r;
        sprot_open_nxt = sprot_open_r;
        if (cmd_wr) begin
            cmd_code_nxt = bus_req.wdata;
            // Any command other than the protect-access code closes access,
            // so a stray write cannot leave protection editable.
            sprot_open_nxt = 1'b0;
            state_nxt = FCUS_LOCKED;
            case (state_r)
                FCUS_LOCKED: begin
                    if (cmd == FCUS_CMD_UNLOCK1) begin
                        state_nxt = FCUS_FIRST_SEEN;
                    end
                end
                FCUS_FIRST_SEEN: begin
                    if (cmd == FCUS_CMD_UNLOCK2) begin
                        state_nxt = FCUS_UNLOCKED;
                    end
                end
                FCUS_UNLOCKED: begin
                    if (cmd == FCUS_CMD_PAGE_ERASE) begin
                        page_erase_go_nxt = 1'b1;
                        erase_page_nxt = page_select;
                    end
                    if (cmd == FCUS_CMD_MASS_ERASE) begin
                        mass_erase_go_nxt = 1'b1;
                    end
                end
                default: state_nxt = FCUS_LOCKED;
            endcase
            if (cmd == FCUS_CMD_SPROT) begin
                sprot_open_nxt = 1'b1;
            end
        end
        unlocked_nxt = (state_nxt == FCUS_UNLOCKED);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= FCUS_LOCKED;
            cmd_code_r <= `FCUS_CMD_RESET;
            page_erase_go_r <= 1'b0;
            mass_erase_go_r <= 1'b0;
            erase_page_r <= 7'h00;
            sprot_open_r <= 1'b0;
            unlocked_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_code_r <= cmd_code_nxt;
            page_erase_go_r <= page_erase_go_nxt;
            mass_erase_go_r <= mass_erase_go_nxt;
            erase_page_r <= erase_page_nxt;
            sprot_open_r <= sprot_open_nxt;
            unlocked_r <= unlocked_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sector protect register and read port
    // ------------------------------------------------------------
    logic [7:0] sector_protect_nxt;
    logic [7:0] rd_data_nxt;
    logic [7:0] status_byte;

    // The status byte is a software aid only, so that firmware can follow the
    // sequence although the command register itself cannot be read back.
    assign status_byte = {5'h00, sprot_open_r, state_r == FCUS_FIRST_SEEN, unlocked_r};

    // Read data are a one-cycle registered pulse that falls back to zero, so a
    // master that samples late sees zero rather than stale data. Unmapped and
    // write-only addresses read as zero for the same reason.
    always_comb begin
        sector_protect_nxt = sector_protect_r;
        if (sprot_wr && sprot_open_r) begin
            sector_protect_nxt = bus_req.wdata;
        end
        rd_data_nxt = 8'h00;
        if (bus_req.rd) begin
            if (lot_hit) begin
                rd_data_nxt = lot_data;
            end else if (bus_req.addr == `FCUS_ADDR_SPROT && sprot_open_r) begin
                rd_data_nxt = sector_protect_r;
            end else if (bus_req.addr == `FCUS_ADDR_STATUS) begin
                rd_data_nxt = status_byte;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sector_protect_r <= `FCUS_SPROT_RESET;
            rd_data_r <= 8'h00;
        end else begin
            sector_protect_r <= sector_protect_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Every check samples the bus as the master drives it: one-cycle strobes,
    // never a read and a write together. A master that holds a strobe longer
    // is seen as a second access, which the sequence treats as a new command.

    sequence unlock_pair;
        cmd_wr && bus_req.wdata == `FCUS_CODE_UNLOCK1 && state_r == FCUS_LOCKED
        ##1 cmd_wr && bus_req.wdata == `FCUS_CODE_UNLOCK2;
    endsequence

    first_byte_arms_a: assert property (
        cmd_wr && bus_req.wdata == `FCUS_CODE_UNLOCK1 && state_r == FCUS_LOCKED
        |=> state_r == FCUS_FIRST_SEEN && !unlocked_r)
        else $error("first unlock byte did not arm the sequence");

    pair_unlocks_a: assert property (
        unlock_pair |=> unlocked_r)
        else $error("unlock pair did not unlock");

    unlock_needs_pair_a: assert property (
        $rose(unlocked_r) |-> $past(state_r) == FCUS_FIRST_SEEN
            && $past(bus_req.wdata) == `FCUS_CODE_UNLOCK2)
        else $error("unlocked without the second byte");

    page_erase_third_a: assert property (
        unlock_pair ##1 cmd_wr && bus_req.wdata == `FCUS_CODE_PAGE_ERASE
        |=> page_erase_go_r && erase_page_r == $past(page_select) ##1 !page_erase_go_r)
        else $error("page erase not started as third command");

    page_erase_cause_a: assert property (
        page_erase_go_r |-> $past(state_r) == FCUS_UNLOCKED && $past(cmd_wr)
            && $past(bus_req.wdata) == `FCUS_CODE_PAGE_ERASE)
        else $error("page erase started out of sequence");

    mass_erase_cause_a: assert property (
        mass_erase_go_r |-> $past(unlocked_r) && $past(cmd_wr)
            && $past(bus_req.wdata) == `FCUS_CODE_MASS_ERASE && !page_erase_go_r)
        else $error("mass erase started out of sequence");

    sprot_access_a: assert property (
        cmd_wr && bus_req.wdata == `FCUS_CODE_SPROT
        ##1 sprot_wr ##1 bus_req.rd && bus_req.addr == `FCUS_ADDR_SPROT
        |=> rd_data_r == $past(bus_req.wdata, 2))
        else $error("sector protect write not read back after access code");

    sprot_guard_a: assert property (
        sprot_wr && !sprot_open_r |=> $stable(sector_protect_r))
        else $error("sector protect written while closed");

    lot_msb_read_a: assert property (
        bus_req.rd && bus_req.addr == `FCUS_ADDR_LOT_LO |=> rd_data_r == LOT_ID[255:248])
        else $error("lot id byte 31 wrong");

    lot_lsb_read_a: assert property (
        bus_req.rd && bus_req.addr == `FCUS_ADDR_LOT_HI |=> rd_data_r == LOT_ID[7:0])
        else $error("lot id byte 0 wrong");

    stray_relocks_a: assert property (
        cmd_wr && cmd == FCUS_CMD_OTHER |=> state_r == FCUS_LOCKED && !unlocked_r ##1 !unlocked_r)
        else $error("stray command did not relock");

    // Unlock sequence and command register.
    cmd_code_track_a: assert property (
        cmd_wr |=> cmd_code_r == $past(bus_req.wdata))
        else $error("command code not captured");

    first_seen_cause_a: assert property (
        $rose(state_r == FCUS_FIRST_SEEN) |-> $past(state_r) == FCUS_LOCKED
            && $past(cmd_wr) && $past(bus_req.wdata) == `FCUS_CODE_UNLOCK1)
        else $error("first byte state entered without the first unlock byte");

    cmd_write_only_a: assert property (
        bus_req.rd && bus_req.addr == `FCUS_ADDR_CMD |=> rd_data_r == 8'h00)
        else $error("command register read back");

    status_bits_a: assert property (
        bus_req.rd && bus_req.addr == `FCUS_ADDR_STATUS
        |=> rd_data_r[`FCUS_ST_UNLOCKED] == $past(unlocked_r)
            && rd_data_r[`FCUS_ST_FIRST] == ($past(state_r) == FCUS_FIRST_SEEN)
            && rd_data_r[`FCUS_ST_SPROT_OPEN] == $past(sprot_open_r))
        else $error("status byte does not show the sequencer state");

    // Erase start pulses.
    locked_no_erase_a: assert property (
        cmd_wr && !unlocked_r |=> !page_erase_go_r && !mass_erase_go_r)
        else $error("erase started from a locked sequencer");

    page_pulse_once_a: assert property (
        page_erase_go_r |=> !page_erase_go_r)
        else $error("page erase pulse longer than one cycle");

    erase_page_hold_a: assert property (
        !page_erase_go_r |-> $stable(erase_page_r))
        else $error("erase page changed without a page erase");

    mass_pulse_once_a: assert property (
        mass_erase_go_r |=> !mass_erase_go_r)
        else $error("mass erase pulse longer than one cycle");

    // Sector protect access and the read port.
    sprot_open_cause_a: assert property (
        $rose(sprot_open_r) |-> $past(cmd_wr)
            && $past(bus_req.wdata) == `FCUS_CODE_SPROT)
        else $error("protect access opened without the access code");

    sprot_write_lands_a: assert property (
        sprot_wr && sprot_open_r |=> sector_protect_r == $past(bus_req.wdata))
        else $error("open sector protect write did not land");

    sprot_closed_read_a: assert property (
        bus_req.rd && bus_req.addr == `FCUS_ADDR_SPROT && !sprot_open_r
        |=> rd_data_r == 8'h00)
        else $error("closed sector protect register read back");

    lot_gap_zero_a: assert property (
        bus_req.rd && bus_req.addr == 16'hFE60 |=> rd_data_r == 8'h00)
        else $error("gap in the lot id map returned data");

    // Relock after an erase command.
    erase_relocks_a: assert property (
        page_erase_go_r || mass_erase_go_r |-> state_r == FCUS_LOCKED && !unlocked_r)
        else $error("sequencer still unlocked after an erase command");

    cov_page_erase_c: cover property (unlock_pair ##1 page_erase_go_nxt);
    cov_mass_erase_c: cover property (unlock_pair ##1 mass_erase_go_nxt);
    cov_sprot_c: cover property (sprot_open_r && sprot_wr);
    cov_relock_c: cover property (state_r == FCUS_FIRST_SEEN && cmd_wr && cmd == FCUS_CMD_OTHER);
    cov_sprot_read_c: cover property (sprot_open_r && bus_req.rd && bus_req.addr == `FCUS_ADDR_SPROT);

endmodule // fcus_top

// >>> sim/fcus_top_tb.sv
// Self-checking bench for the flash command unlock sequencer top.
// Assumes fcus_pkg is compiled first and fcus_cfg.svh is on the include path.
`timescale 1ns/1ps
`include "fcus_cfg.svh"

module fcus_top_tb;
    import fcus_pkg::*;

    // ------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------
    function automatic logic [255:0] lot_val();
        logic [255:0] v;
        for (int k = 0; k < 32; k++) begin
            v[k*8 +: 8] = 8'(k * 5 + 8'h21);
        end
        return v;
    endfunction
    localparam logic [255:0] LOT = lot_val();
    // Low address bytes of the scattered identifier, byte 31 first.
    localparam logic [7:0] LOT_LO [32] = '{8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h58, 8'h59, 8'h5A,
        8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h6A,
        8'h6B, 8'h6D, 8'h6E, 8'h70, 8'h71, 8'h73, 8'h74, 8'h76, 8'h77, 8'h79, 8'h7A, 8'h7C,
        8'h7D};

    logic clock;
    logic rst_b;
    fcus_bus_t bus_req;
    logic [6:0] page_select;
    logic [7:0] rd_data_r;
    logic page_erase_go_r;
    logic mass_erase_go_r;
    logic [6:0] erase_page_r;
    logic [7:0] sector_protect_r;
    logic unlocked_r;
    int miscompares = 0;
    int check_count = 0;
    logic [7:0] got;

    fcus_top #(.LOT_ID(LOT)) i_dut (
        .clock(clock),
        .rst_b(rst_b),
        .bus_req(bus_req),
        .page_select(page_select),
        .rd_data_r(rd_data_r),
        .page_erase_go_r(page_erase_go_r),
        .mass_erase_go_r(mass_erase_go_r),
        .erase_page_r(erase_page_r),
        .sector_protect_r(sector_protect_r),
        .unlocked_r(unlocked_r)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Bus tasks; each starts and ends just after a rising edge
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_req.wr <= 1'b1;
        bus_req.rd <= 1'b0;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge clock);
        #1;
    endtask

    task automatic idle();
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge clock);
        #1;
        d = rd_data_r;
        bus_req.rd <= 1'b0;
        @(posedge clock);
        #1;
        chk("read data idle", 8'h00, rd_data_r);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        bus_req = '0;
        page_select = 7'h55;
        repeat (3) @(posedge clock);
        #1;
        rst_b = 1'b1;
        chk("unlocked reset", 8'h00, {7'h00, unlocked_r});
        chk("protect reset", 8'h00, sector_protect_r);
        rd(`FCUS_ADDR_CMD, got);
        chk("command reg read", `FCUS_CMD_RESET, got);
        rd(16'h1234, got);
        chk("unmapped read", 8'h00, got);
        $display("test reset done");

        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        chk("unlocked after pair", 8'h01, {7'h00, unlocked_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_PAGE_ERASE);
        chk("page go", 8'h01, {7'h00, page_erase_go_r});
        chk("erase page", 8'h55, {1'b0, erase_page_r});
        chk("relocked", 8'h00, {7'h00, unlocked_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_PAGE_ERASE);
        chk("page go one cycle", 8'h00, {7'h00, page_erase_go_r});
        idle();
        chk("fourth code no go", 8'h00, {7'h00, page_erase_go_r});
        $display("test page erase done");

        page_select <= 7'h2A;
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        idle();
        rd(`FCUS_ADDR_STATUS, got);
        chk("status first seen", 8'h02, got);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        idle();
        rd(`FCUS_ADDR_STATUS, got);
        chk("status unlocked", 8'h01, got);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_MASS_ERASE);
        chk("mass go", 8'h01, {7'h00, mass_erase_go_r});
        chk("no page go", 8'h00, {7'h00, page_erase_go_r});
        chk("erase page holds", 8'h55, {1'b0, erase_page_r});
        idle();
        chk("mass go one cycle", 8'h00, {7'h00, mass_erase_go_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_MASS_ERASE);
        chk("mass go back to back", 8'h01, {7'h00, mass_erase_go_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_PAGE_ERASE);
        chk("erase page captured", 8'h2A, {1'b0, erase_page_r});
        $display("test mass erase done");

        // Broken sequences: none of them may start an erase; only the last unlocks, and its third byte relocks.
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_PAGE_ERASE);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_MASS_ERASE);
        chk("lone codes no go", 8'h00, {6'h00, page_erase_go_r, mass_erase_go_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_PAGE_ERASE);
        chk("second position no go", 8'h00, {7'h00, page_erase_go_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, 8'h00);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        chk("stray byte relocks", 8'h00, {7'h00, unlocked_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        chk("repeated first relocks", 8'h00, {7'h00, unlocked_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_MASS_ERASE);
        chk("no mass go when locked", 8'h00, {7'h00, mass_erase_go_r});
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK2);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_UNLOCK1);
        chk("third unlock relocks", 8'h00, {7'h00, unlocked_r});
        idle();
        $display("test broken sequences done");

        wr(`FCUS_ADDR_SPROT, 8'hA5);
        idle();
        chk("protect closed write", 8'h00, sector_protect_r);
        wr(`FCUS_ADDR_CMD, `FCUS_CODE_SPROT);
        wr(`FCUS_ADDR_SPROT, 8'hA5);
        chk("protect open write", 8'hA5, sector_protect_r);
        rd(`FCUS_ADDR_SPROT, got);
        chk("protect open read", 8'hA5, got);
        rd(`FCUS_ADDR_STATUS, got);
        chk("status access open", 8'h04, got);
        wr(`FCUS_ADDR_CMD, 8'h00);
        wr(`FCUS_ADDR_SPROT, 8'h3C);
        idle();
        chk("protect closed again", 8'hA5, sector_protect_r);
        rd(`FCUS_ADDR_SPROT, got);
        chk("protect closed read", 8'h00, got);
        $display("test sector protect done");

        for (int i = 0; i < 32; i++) begin
            rd({8'hFE, LOT_LO[i]}, got);
            chk("lot byte", LOT[(31 - i) * 8 +: 8], got);
        end
        rd(16'hFE3B, got);
        chk("below lot id", 8'h00, got);
        rd(16'hFE7E, got);
        chk("above lot id", 8'h00, got);
        rd(16'hFE60, got);
        chk("lot id gap", 8'h00, got);
        $display("test lot id done");
        tally_and_finish();
    end
endmodule // fcus_top_tb
